// ===== logic/rtc_pkg.sv
// Types shared by the real-time clock tick and alarm timer.
package rtc_pkg;

	// Software controls, held by the system outside the block.
	typedef struct packed {
		logic enable;
		logic tick_irq_en;
		logic ntick_irq_en;
		logic alarm_irq_en;
		logic osc_off_in_powerdown;
		logic powerdown_wake_config;
		logic [1:0] external_irq_source_select;
		logic [19:0] tick_reload_value;
		logic [15:0] ntick_count;
		logic [31:0] alarm_value;
		logic [31:0] wake_delay;
	} rtc_ctrl_s;

	// Readable state of the block.
	typedef struct packed {
		logic lp_osc_selected;
		logic detect_done;
		logic alarm_match;
		logic [19:0] divider;
		logic [31:0] time_value;
		logic [57:0] chain;
	} rtc_stat_s;

	// Oscillator detection after reset.
	typedef enum logic [2:0] {
		RTC_DET = 3'b001,
		RTC_RUN_LP = 3'b010,
		RTC_RUN_MAIN = 3'b100
	} rtc_src_e;

endpackage : rtc_pkg

// ===== logic/rtc_regs.svh
// Constants for the real-time clock tick and alarm timer.
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// ----------------------------------------------------------------------------
// Widths and fixed ratios
// ----------------------------------------------------------------------------
`define RTC_PRESCALE_DIV 64
`define RTC_PRESCALE_W 6
`define RTC_DIV_W 20
`define RTC_TIME_W 32
`define RTC_CHAIN_W 58
`define RTC_NTICK_W 16
`define RTC_WAKE_W 32

// ----------------------------------------------------------------------------
// Field positions of the fast interrupt source select
// ----------------------------------------------------------------------------
`define RTC_EXTERNAL_IRQ_SOURCE_SELECT_TICK 0
`define RTC_EXTERNAL_IRQ_SOURCE_SELECT_ALARM 1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RTC_RST_DIV 20'h00000
`define RTC_RST_TIME 32'h00000000
`define RTC_RST_PRE 6'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define RTC_CLK_PERIOD_NS 4
`define RTC_LP_PERIOD_NS 30518
`define RTC_DET_WIN_NS (4 * `RTC_LP_PERIOD_NS)
`define RTC_DET_WIN_CYC (`RTC_DET_WIN_NS / `RTC_CLK_PERIOD_NS)
`define RTC_DET_MIN_EDGES 2

`endif

// ===== logic/rtc_reload_cnt.sv
// Reloadable down counter that pulses when it wraps through zero.
module rtc_reload_cnt #(
	parameter int W = 20
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Control
	input wire logic restart,
	input wire logic step,
	input wire logic [W-1:0] reload,
	// Result
	output logic [W-1:0] count,
	output logic expire
);

	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	wire at_zero = (cnt_q == '0);

	// A reload of zero gives one expiry for every step.
	assign expire = step & at_zero & ~restart;
	assign cnt_d = restart ? reload : (at_zero ? reload : cnt_q - W'(1));
	assign count = cnt_q;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= '0;
		end else if (restart | step) begin
			cnt_q <= cnt_d;
		end
	end

endmodule : rtc_reload_cnt

// ===== logic/rtc_tick_alarm.sv
// Real-time clock: prescaler, tick divider, time counter, alarm and oscillator control.
// Summary of operation
// - Counts from main or low-power oscillator.
// - Fixed divide-by-64 prescale feeds divider.
// - 20-bit divider reloads every basic tick.
// - Tick request each tick and every n.
// - Writable 32-bit time counter increments per tick.
// - Alarm request when time equals alarm.
// - Prescale, divider, counter form 58-bit chain.
// - Tick and alarm routable to fast interrupt.
// - Delayed wake only with wake config set.
// - Oscillator-off bit stops clock in power-down.
// - Disabled clock turns both oscillators off in power-down.
// - Detect low-power oscillation after every reset.
// - Low-power source: main oscillator off in power-down.
// - Main source keeps main oscillator in power-down unless disabled or oscillator-off set.
// - Standby counting only on low-power source.
// - Prescaler, divider, time, match and source state readable by software.
`include "rtc_regs.svh"

module rtc_tick_alarm #(
	parameter int DET_WIN_CYC = `RTC_DET_WIN_CYC,
	parameter int DET_MIN_EDGES = `RTC_DET_MIN_EDGES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Oscillator pin
	input wire logic low_power_osc_input,
	// Software controls
	input wire rtc_pkg::rtc_ctrl_s ctrl,
	input wire logic time_wr,
	input wire logic [31:0] time_wdata,
	// Chip power state
	input wire logic powerdown,
	input wire logic standby,
	// Requests
	output logic tick_interrupt_request,
	output logic alarm_interrupt_request,
	output logic fast_ext_irq,
	output logic powerdown_wake,
	// Oscillator switches
	output logic main_osc_off,
	output logic lp_osc_off,
	// Readable state
	output rtc_pkg::rtc_stat_s status
);

	// ------------------------------------------------------------------------
	// Low-power oscillator sampling
	// ------------------------------------------------------------------------

	logic lp_s1_q;
	logic lp_s2_q;
	logic lp_s3_q;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			lp_s1_q <= 1'b0;
			lp_s2_q <= 1'b0;
			lp_s3_q <= 1'b0;
		end else begin
			lp_s1_q <= low_power_osc_input;
			lp_s2_q <= lp_s1_q;
			lp_s3_q <= lp_s2_q;
		end
	end

	wire lp_rise = lp_s2_q & ~lp_s3_q;

	// ------------------------------------------------------------------------
	// Source detection after reset
	// ------------------------------------------------------------------------

	// The window spans several low-power periods so a single glitch on the
	// pin cannot select a source that is not really oscillating.
	rtc_pkg::rtc_src_e src_q;
	rtc_pkg::rtc_src_e src_d;
	logic [31:0] win_q;
	logic [7:0] edges_q;

	wire win_end = (win_q == 32'(DET_WIN_CYC - 1));
	wire enough_edges = (edges_q >= 8'(DET_MIN_EDGES));

	always_comb begin
		src_d = src_q;
		case (src_q)
			rtc_pkg::RTC_DET: begin
				if (win_end) begin
					src_d = enough_edges ? rtc_pkg::RTC_RUN_LP : rtc_pkg::RTC_RUN_MAIN;
				end
			end
			rtc_pkg::RTC_RUN_LP: src_d = rtc_pkg::RTC_RUN_LP;
			rtc_pkg::RTC_RUN_MAIN: src_d = rtc_pkg::RTC_RUN_MAIN;
			default: src_d = rtc_pkg::RTC_DET;
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			src_q <= rtc_pkg::RTC_DET;
		end else begin
			src_q <= src_d;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			win_q <= 32'h00000000;
		end else if (src_q == rtc_pkg::RTC_DET) begin
			win_q <= win_q + 32'h00000001;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			edges_q <= 8'h00;
		end else if (src_q == rtc_pkg::RTC_DET && lp_rise && !enough_edges) begin
			edges_q <= edges_q + 8'h01;
		end
	end

	wire lp_sel = (src_q == rtc_pkg::RTC_RUN_LP);
	wire detect_done = (src_q != rtc_pkg::RTC_DET);

	// ------------------------------------------------------------------------
	// Run conditions
	// ------------------------------------------------------------------------

	// In standby the main supply is gone, so only a low-power source can keep
	// counting. The oscillator-off bit also stops the count in power-down.
	wire osc_stopped = powerdown & ctrl.osc_off_in_powerdown;
	wire standby_halt = standby & ~lp_sel;
	wire run = ctrl.enable & detect_done & ~osc_stopped & ~standby_halt;

	// One source pulse per rising edge of the low-power clock, or every cycle of the
	// main clock when no low-power oscillation was found.
	wire src_pulse = run & (lp_sel ? lp_rise : 1'b1);

	// ------------------------------------------------------------------------
	// Fixed prescaler
	// ------------------------------------------------------------------------

	logic [`RTC_PRESCALE_W-1:0] pre_q;

	wire pre_wrap = src_pulse & (pre_q == `RTC_PRESCALE_W'(`RTC_PRESCALE_DIV - 1));

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pre_q <= `RTC_RST_PRE;
		end else if (src_pulse) begin
			pre_q <= pre_q + `RTC_PRESCALE_W'(1);
		end
	end

	// ------------------------------------------------------------------------
	// Tick divider
	// ------------------------------------------------------------------------

	logic [`RTC_DIV_W-1:0] div_count;
	logic tick;

	// The divider counts down and reloads at every basic tick, so a reload of
	// R gives a tick every R+1 prescaled steps.
	rtc_reload_cnt #(
		.W(`RTC_DIV_W)
	) u_divider (
		.mclk(mclk),
		.nrst(nrst),
		.restart(~ctrl.enable),
		.step(pre_wrap),
		.reload(ctrl.tick_reload_value),
		.count(div_count),
		.expire(tick)
	);

	// ------------------------------------------------------------------------
	// Every-n-ticks counter
	// ------------------------------------------------------------------------

	logic ntick_expire;

	rtc_reload_cnt #(
		.W(`RTC_NTICK_W)
	) u_ntick (
		.mclk(mclk),
		.nrst(nrst),
		.restart(~ctrl.ntick_irq_en),
		.step(tick),
		.reload(ctrl.ntick_count),
		.count(),
		.expire(ntick_expire)
	);

	// ------------------------------------------------------------------------
	// Time counter and alarm
	// ------------------------------------------------------------------------

	logic [`RTC_TIME_W-1:0] time_q;
	logic [`RTC_TIME_W-1:0] time_d;
	logic match_q;

	// A software write wins over a tick landing in the same cycle.
	assign time_d = time_wr ? time_wdata : time_q + `RTC_TIME_W'(1);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			time_q <= `RTC_RST_TIME;
		end else if (time_wr | tick) begin
			time_q <= time_d;
		end
	end

	wire match = (time_q == ctrl.alarm_value);
	wire match_rise = match & ~match_q;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			match_q <= 1'b0;
		end else begin
			match_q <= match;
		end
	end

	// ------------------------------------------------------------------------
	// Interrupt requests
	// ------------------------------------------------------------------------

	wire tick_req_d = (tick & ctrl.tick_irq_en) | (ntick_expire & ctrl.ntick_irq_en);
	wire alarm_req_d = match_rise & ctrl.alarm_irq_en;
	wire fast_d = (tick_req_d & ctrl.external_irq_source_select[`RTC_EXTERNAL_IRQ_SOURCE_SELECT_TICK]) |
		(alarm_req_d & ctrl.external_irq_source_select[`RTC_EXTERNAL_IRQ_SOURCE_SELECT_ALARM]);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			tick_interrupt_request <= 1'b0;
			alarm_interrupt_request <= 1'b0;
			fast_ext_irq <= 1'b0;
		end else begin
			tick_interrupt_request <= tick_req_d;
			alarm_interrupt_request <= alarm_req_d;
			fast_ext_irq <= fast_d;
		end
	end

	// ------------------------------------------------------------------------
	// Delayed wake from power-down
	// ------------------------------------------------------------------------

	logic wake_expire;

	// The delay restarts on every entry to power-down and counts basic ticks.
	rtc_reload_cnt #(
		.W(`RTC_WAKE_W)
	) u_wake (
		.mclk(mclk),
		.nrst(nrst),
		.restart(~powerdown),
		.step(tick),
		.reload(ctrl.wake_delay),
		.count(),
		.expire(wake_expire)
	);

	wire wake_d = powerdown & ((wake_expire & ctrl.powerdown_wake_config) | fast_d);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			powerdown_wake <= 1'b0;
		end else begin
			powerdown_wake <= wake_d;
		end
	end

	// ------------------------------------------------------------------------
	// Oscillator switches
	// ------------------------------------------------------------------------

	// Until detection is done both oscillators stay on, since the choice of
	// source is not known yet.
	wire pd_disabled = powerdown & ~ctrl.enable;
	wire main_off_d = detect_done & (pd_disabled | (powerdown & lp_sel) |
		(powerdown & ~lp_sel & ctrl.osc_off_in_powerdown));
	wire lp_off_d = detect_done & (pd_disabled | (powerdown & lp_sel & ctrl.osc_off_in_powerdown) |
		~lp_sel);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			main_osc_off <= 1'b0;
			lp_osc_off <= 1'b0;
		end else begin
			main_osc_off <= main_off_d;
			lp_osc_off <= lp_off_d;
		end
	end

	// ------------------------------------------------------------------------
	// Readable state
	// ------------------------------------------------------------------------

	assign status.lp_osc_selected = lp_sel;
	assign status.detect_done = detect_done;
	assign status.alarm_match = match_q;
	assign status.divider = div_count;
	assign status.time_value = time_q;
	assign status.chain = {time_q, div_count, pre_q};

endmodule : rtc_tick_alarm

// ===== test/rtc_osc_model.sv
// Model of the low-power oscillator pin, sped up so that detection stays short.
module rtc_osc_model (
	// Control
	input wire logic present,
	// Pin
	output logic osc
);
	timeunit 1ns;
	timeprecision 1ps;
	initial osc = 1'b0;
	// A missing crystal leaves the pin still, so detection sees no edges.
	always #16 osc = present & ~osc;
endmodule : rtc_osc_model

// ===== test/rtc_tick_alarm_asserts.sv
// Checker bound to the ports of the real-time clock tick and alarm timer.
module rtc_tick_alarm_asserts #(
	parameter int DET_WIN_CYC = 64,
	parameter int DET_MIN_EDGES = 2
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Inputs
	input wire rtc_pkg::rtc_ctrl_s ctrl,
	input wire logic time_wr,
	input wire logic [31:0] time_wdata,
	input wire logic powerdown,
	input wire logic standby,
	// Outputs
	input wire logic tick_interrupt_request,
	input wire logic alarm_interrupt_request,
	input wire logic fast_ext_irq,
	input wire logic powerdown_wake,
	input wire logic main_osc_off,
	input wire logic lp_osc_off,
	input wire rtc_pkg::rtc_stat_s status
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	// Enable is part of the cause, since a disabled divider may legally reload.
	sequence s_stopped;
		ctrl.enable && ((powerdown && ctrl.osc_off_in_powerdown) || (standby && !status.lp_osc_selected));
	endsequence
	sequence s_idle;
		!ctrl.enable [*2];
	endsequence

	tick_routed_a: assert property (
		tick_interrupt_request && ctrl.external_irq_source_select[0] |-> fast_ext_irq
	) else $error("tick request not routed");
	alarm_pulse_a: assert property (
		alarm_interrupt_request == ($rose(status.alarm_match) && $past(ctrl.alarm_irq_en))
	) else $error("alarm request not tied to a new match");
	tick_time_a: assert property (
		tick_interrupt_request && !$past(time_wr) |-> status.time_value == $past(status.time_value) + 32'h1
	) else $error("time did not step with tick");
	time_write_a: assert property (
		time_wr |=> status.time_value == $past(time_wdata)
	) else $error("time write lost");
	idle_tick_a: assert property (
		s_idle |-> !tick_interrupt_request
	) else $error("tick while disabled");
	stop_hold_a: assert property (
		s_stopped ##1 s_stopped |-> $stable(status.divider)
	) else $error("divider moved while stopped");
	disabled_off_a: assert property (
		powerdown && !ctrl.enable && status.detect_done |=> main_osc_off && lp_osc_off
	) else $error("oscillators left on while disabled");
	lp_main_off_a: assert property (
		powerdown && status.lp_osc_selected |=> main_osc_off
	) else $error("main oscillator left on");
	main_kept_a: assert property (
		powerdown && ctrl.enable && !ctrl.osc_off_in_powerdown && status.detect_done
			&& !status.lp_osc_selected |=> !main_osc_off
	) else $error("main oscillator stopped while needed");
	chain_split_a: assert property (
		status.chain[57:26] == status.time_value && status.chain[25:6] == status.divider
	) else $error("timer chain does not hold time and divider");
	wake_gate_a: assert property (
		powerdown_wake |-> $past(ctrl.powerdown_wake_config) || fast_ext_irq
	) else $error("wake without configuration");
endmodule : rtc_tick_alarm_asserts

bind rtc_tick_alarm rtc_tick_alarm_asserts #(
	.DET_WIN_CYC(DET_WIN_CYC),
	.DET_MIN_EDGES(DET_MIN_EDGES)
) rtc_tick_alarm_asserts_inst (
	.mclk, .nrst, .ctrl, .time_wr, .time_wdata, .powerdown, .standby,
	.tick_interrupt_request, .alarm_interrupt_request, .fast_ext_irq,
	.powerdown_wake, .main_osc_off, .lp_osc_off, .status
);

// ===== test/rtc_tick_alarm_tb_top.sv
// Self-checking testbench for the real-time clock tick and alarm timer.
module rtc_tick_alarm_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic lp_on = 1'b0;
	logic lp_pin;
	rtc_pkg::rtc_ctrl_s ctrl = '0;
	logic time_wr = 1'b0;
	logic [31:0] time_wdata = 32'h0;
	logic powerdown = 1'b0;
	logic standby = 1'b0;
	logic tick_irq, alarm_irq, fast_irq, pd_wake, main_off, lp_off;
	rtc_pkg::rtc_stat_s status;
	int error_cnt = 0;
	int checks = 0;
	int cyc = 0;
	int last_cyc = 0;
	int wakes = 0;
	logic [31:0] last_time = 32'h0;
	int exp_gap[$];
	int exp_step[$];
	logic [31:0] exp_alarm[$];

	always #2 mclk = ~mclk;
	always @(posedge mclk) cyc <= cyc + 1;

	rtc_osc_model rtc_osc_model_inst (.present(lp_on), .osc(lp_pin));

	rtc_tick_alarm #(.DET_WIN_CYC(64)) rtc_tick_alarm_inst (
		.mclk(mclk), .nrst(nrst), .low_power_osc_input(lp_pin), .ctrl(ctrl),
		.time_wr(time_wr), .time_wdata(time_wdata), .powerdown(powerdown),
		.standby(standby), .tick_interrupt_request(tick_irq),
		.alarm_interrupt_request(alarm_irq), .fast_ext_irq(fast_irq),
		.powerdown_wake(pd_wake), .main_osc_off(main_off), .lp_osc_off(lp_off),
		.status(status)
	);

	task automatic chk(input string what, input logic [57:0] exp, input logic [57:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic close_out();
		if (error_cnt == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out

	// --------------------------------------------------------------------
	// Result watcher
	// --------------------------------------------------------------------
	// The first tick of a round has an unknown prescaler phase, so its gap is skipped.
	always @(posedge mclk) begin
		#1;
		if (pd_wake === 1'b1) wakes++;
		if (alarm_irq === 1'b1) begin
			if (exp_alarm.size() == 0) chk("alarm", 58'h0, 58'h1);
			else chk("alarm time", 58'(exp_alarm.pop_front()), 58'(status.time_value));
		end
		if (tick_irq === 1'b1) begin
			if (exp_gap.size() == 0) begin
				chk("tick", 58'h0, 58'h1);
			end else if (exp_gap[0] == 0) begin
				void'(exp_gap.pop_front());
				void'(exp_step.pop_front());
			end else begin
				chk("tick gap", 58'(exp_gap.pop_front()), 58'(cyc - last_cyc));
				chk("time step", 58'(exp_step.pop_front()), 58'(status.time_value - last_time));
			end
			last_cyc = cyc;
			last_time = status.time_value;
		end
	end

	task automatic drain();
		int n;
		n = 0;
		while (exp_gap.size() + exp_alarm.size() != 0) begin
			@(posedge mclk);
			n++;
			if (n > 5000) begin
				error_cnt++;
				close_out();
			end
		end
	endtask : drain

	task automatic do_reset(input logic lp);
		int n;
		n = 0;
		lp_on = lp;
		nrst <= 1'b0;
		repeat (4) @(posedge mclk);
		nrst <= 1'b1;
		while (status.detect_done !== 1'b1) begin
			@(posedge mclk);
			n++;
			if (n > 1000) begin
				error_cnt++;
				close_out();
			end
		end
		// The oscillator switches are registered one cycle behind detection.
		@(negedge mclk);
		chk("lp source", 58'(lp), 58'(status.lp_osc_selected));
		chk("lp osc off", 58'(!lp), 58'(lp_off));
	endtask : do_reset

	task automatic round(input int r, input int n, input int k);
		@(posedge mclk);
		ctrl.tick_reload_value <= 20'(r);
		ctrl.tick_irq_en <= (n == 1);
		ctrl.ntick_irq_en <= (n != 1);
		ctrl.ntick_count <= 16'(n - 1);
		exp_gap.push_back(0);
		exp_step.push_back(0);
		for (int i = 1; i < k; i++) begin
			exp_gap.push_back(64 * (r + 1) * n);
			exp_step.push_back(n);
		end
		ctrl.enable <= 1'b1;
		drain();
		ctrl.enable <= 1'b0;
	endtask : round

	task automatic stalled(input logic pd, input logic sb);
		logic [19:0] d;
		@(posedge mclk);
		powerdown <= pd;
		ctrl.osc_off_in_powerdown <= pd;
		standby <= sb;
		ctrl.enable <= 1'b1;
		repeat (3) @(posedge mclk);
		d = status.divider;
		repeat (300) @(posedge mclk);
		chk("held divider", 58'(d), 58'(status.divider));
		powerdown <= 1'b0;
		ctrl.osc_off_in_powerdown <= 1'b0;
		standby <= 1'b0;
		ctrl.enable <= 1'b0;
	endtask : stalled

	initial begin
		logic [31:0] w;
		void'($urandom(32'h12ce));
		do_reset(1'b0);
		round(0, 1, 3);
		round($urandom_range(3, 1), 1, 3);
		round(0, 3, 3);
		w = $urandom >> 1;
		@(posedge mclk);
		time_wr <= 1'b1;
		time_wdata <= w;
		@(posedge mclk);
		time_wr <= 1'b0;
		ctrl.alarm_value <= w + 32'h2;
		ctrl.alarm_irq_en <= 1'b1;
		ctrl.external_irq_source_select <= 2'b11;
		@(posedge mclk);
		chk("written time", 58'(w), 58'(status.time_value));
		exp_alarm.push_back(w + 32'h2);
		round($urandom_range(3, 0), 1, 3);
		@(posedge mclk);
		ctrl.alarm_irq_en <= 1'b0;
		ctrl.external_irq_source_select <= 2'b00;
		ctrl.powerdown_wake_config <= 1'b1;
		powerdown <= 1'b1;
		wakes = 0;
		round(0, 1, 3);
		chk("wake seen", 58'h1, 58'(wakes != 0));
		chk("main osc kept", 58'h0, 58'(main_off));
		ctrl.powerdown_wake_config <= 1'b0;
		wakes = 0;
		round(0, 1, 3);
		chk("wake blocked", 58'h0, 58'(wakes));
		powerdown <= 1'b0;
		stalled(1'b1, 1'b0);
		stalled(1'b0, 1'b1);
		powerdown <= 1'b1;
		repeat (3) @(posedge mclk);
		chk("main osc off", 58'h1, 58'(main_off));
		chk("lp osc off", 58'h1, 58'(lp_off));
		powerdown <= 1'b0;
		do_reset(1'b1);
		standby <= 1'b1;
		round(0, 1, 1);
		powerdown <= 1'b1;
		repeat (3) @(posedge mclk);
		chk("main osc off", 58'h1, 58'(main_off));
		close_out();
	end
endmodule : rtc_tick_alarm_tb_top
